// *** logic/spfs_pin_mux.sv ***
// Local design decisions: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module spfs_pin_mux
	import spfs_pkg::*;
(
	// System clock and external reset.
	input  wire logic                   i_sys_clk,
	input  wire logic                   i_rst_b,
	// APB slave.
	input  wire logic                   i_psel,
	input  wire logic                   i_penable,
	input  wire logic                   i_pwrite,
	input  wire logic [SPFS_ADDR_W-1:0] i_paddr,
	input  wire logic [SPFS_DATA_W-1:0] i_pwdata,
	output logic      [SPFS_DATA_W-1:0] o_prdata,
	output logic                        o_pready,
	output logic                        o_pslverr,
	// Shared pins, output enable low while driving.
	input  wire logic [SPFS_PIN_N-1:0]  i_pin,
	output logic      [SPFS_PIN_N-1:0]  o_pin_out,
	output logic      [SPFS_PIN_N-1:0]  o_pin_oe_b,
	// Dedicated input pins.
	input  wire logic                   i_nmi_pin,
	input  wire logic [SPFS_MODE_W-1:0] i_operating_mode_pins,
	// Peripheral side, serial channel 3 clock.
	input  wire logic                   i_ser3_clk_out,
	output logic                        o_ser3_clk_in,
	// Peripheral side, serial channel 4.
	input  wire logic                   i_serial_ch4_tx,
	input  wire logic                   i_serial_ch4_clk_out,
	output logic                        o_serial_ch4_rx,
	output logic                        o_serial_ch4_clk_in,
	// Peripheral side, synchronous serial interface.
	input  wire logic                   i_sync_serial_tx,
	input  wire logic                   i_sync_serial_clk_out,
	output logic                        o_sync_serial_rx,
	output logic                        o_sync_serial_clk_in,
	// Peripheral side, DMA request, NMI and mode.
	output logic                        o_dma_ch2_request_in,
	output logic                        o_nmi_req,
	output logic      [SPFS_MODE_W-1:0] o_operating_mode,
	output logic                        o_mode_valid
);

	logic [SPFS_SYNC_W-1:0] sync_lvl;
	logic [SPFS_CTRL_W-1:0] ctrl_reg,  ctrl_next;
	logic [SPFS_PIN_N-1:0]  dir_reg,   dir_next;
	logic [SPFS_PIN_N-1:0]  data_reg,  data_next;
	logic [SPFS_DATA_W-1:0] prdata_reg, prdata_next;
	logic                   pready_reg, pready_next;
	logic                   pslverr_reg, pslverr_next;
	logic [SPFS_PIN_N-1:0]  pout_reg,  pout_next;
	logic [SPFS_PIN_N-1:0]  poeb_reg,  poeb_next;
	logic [SPFS_PIN_N-1:0]  fsel;
	logic [SPFS_PIN_N-1:0]  fdrive;
	logic [SPFS_PIN_N-1:0]  fval;
	logic [6:0]             pin_in_reg, pin_in_next;
	logic [SPFS_MODE_W-1:0] mode_reg,  mode_next;
	logic                   mvalid_reg, mvalid_next;
	logic [1:0]             live_reg,  live_next;
	logic                   setup_ph;
	logic                   wr_acc;

	// Every pin input crosses two flip-flops before anything looks at it.
	spfs_sync2 #(
		.WIDTH (SPFS_SYNC_W)
	) u_sync (
		.i_sys_clk (i_sys_clk),
		.i_rst_b   (i_rst_b),
		.i_async   ({i_operating_mode_pins, i_nmi_pin, i_pin}),
		.o_sync    (sync_lvl)
	);

	// Peripheral function selection per pin; input-only functions never claim the driver.
	always_comb
	begin
		fsel   = '0;
		fdrive = '0;
		fval   = '0;
		fsel[SPFS_P_H_BIT5]   = ctrl_reg[SPFS_B_CH3_CLK_OUT] | ctrl_reg[SPFS_B_CH3_EXT_CLK];
		fdrive[SPFS_P_H_BIT5] = ctrl_reg[SPFS_B_CH3_CLK_OUT];
		fval[SPFS_P_H_BIT5]   = i_ser3_clk_out;
		fsel[SPFS_P_G_BIT1]   = ctrl_reg[SPFS_B_CH4_TX_EN];
		fdrive[SPFS_P_G_BIT1] = 1'b1;
		fval[SPFS_P_G_BIT1]   = i_serial_ch4_tx;
		fsel[SPFS_P_G_BIT2]   = ctrl_reg[SPFS_B_CH4_CLK_OUT] | ctrl_reg[SPFS_B_CH4_EXT_CLK];
		fdrive[SPFS_P_G_BIT2] = ctrl_reg[SPFS_B_CH4_CLK_OUT];
		fval[SPFS_P_G_BIT2]   = i_serial_ch4_clk_out;
		fsel[SPFS_P_G_BIT4]   = ctrl_reg[SPFS_B_SYNC_TX_EN];
		fdrive[SPFS_P_G_BIT4] = 1'b1;
		fval[SPFS_P_G_BIT4]   = i_sync_serial_tx;
		fsel[SPFS_P_G_BIT5]   = ctrl_reg[SPFS_B_SYNC_CLK_OUT] | ctrl_reg[SPFS_B_SYNC_EXT_SHFT];
		fdrive[SPFS_P_G_BIT5] = ctrl_reg[SPFS_B_SYNC_CLK_OUT];
		fval[SPFS_P_G_BIT5]   = i_sync_serial_clk_out;
	end

	// A selected peripheral owns the pin; otherwise the port bits decide, one pin per iteration.
	for (genvar gi = 0; gi < SPFS_PIN_N; gi++)
	begin : g_pin
		always_comb
		begin
			if (fsel[gi])
			begin
				pout_next[gi] = fdrive[gi] ? fval[gi] : data_reg[gi];
				poeb_next[gi] = ~fdrive[gi];
			end
			else
			begin
				pout_next[gi] = data_reg[gi];
				poeb_next[gi] = ~dir_reg[gi];
			end
		end
	end

	// Receive-side levels to the peripherals; clock inputs are passed only in external mode.
	always_comb
	begin
		pin_in_next[0] = sync_lvl[SPFS_P_G_BIT0];
		pin_in_next[1] = sync_lvl[SPFS_P_G_BIT2] & ctrl_reg[SPFS_B_CH4_EXT_CLK];
		pin_in_next[2] = sync_lvl[SPFS_P_G_BIT3];
		pin_in_next[3] = sync_lvl[SPFS_P_G_BIT5] & ctrl_reg[SPFS_B_SYNC_EXT_SHFT];
		pin_in_next[4] = sync_lvl[SPFS_P_H_BIT5] & ctrl_reg[SPFS_B_CH3_EXT_CLK];
		pin_in_next[5] = sync_lvl[SPFS_P_C_BIT0] & ctrl_reg[SPFS_B_DMA2_REQ_SEL];
		pin_in_next[6] = sync_lvl[SPFS_S_NMI];
	end

	// Mode pins are caught once, after the synchroniser has filled; a strap never moves later.
	always_comb
	begin
		live_next   = (live_reg == SPFS_LIVE_MAX) ? live_reg : live_reg + 2'h1;
		mode_next   = mode_reg;
		mvalid_next = mvalid_reg;
		if (!mvalid_reg && live_reg == SPFS_MODE_SETTLE)
		begin
			mode_next   = sync_lvl[SPFS_S_MODE_LSB +: SPFS_MODE_W];
			mvalid_next = 1'b1;
		end
	end

	// APB: answer in the first access cycle, so every transfer has no wait state.
	assign setup_ph = i_psel & ~i_penable;
	assign wr_acc   = i_psel & i_penable & pready_reg & i_pwrite;

	always_comb
	begin
		pready_next  = setup_ph;
		pslverr_next = 1'b0;
		prdata_next  = '0;
		if (setup_ph)
		begin
			if (i_paddr == SPFS_OFS_CTRL)
			begin
				prdata_next = {{(SPFS_DATA_W-SPFS_CTRL_W){1'b0}}, ctrl_reg};
			end
			else if (i_paddr == SPFS_OFS_DIR)
			begin
				prdata_next = {{(SPFS_DATA_W-SPFS_PIN_N){1'b0}}, dir_reg};
			end
			else if (i_paddr == SPFS_OFS_DATA)
			begin
				prdata_next = {{(SPFS_DATA_W-SPFS_PIN_N){1'b0}}, data_reg};
			end
			else if (i_paddr == SPFS_OFS_LEVEL)
			begin
				prdata_next = {{(SPFS_DATA_W-SPFS_PIN_N){1'b0}}, sync_lvl[SPFS_PIN_N-1:0]};
			end
			else if (i_paddr == SPFS_OFS_STATUS)
			begin
				prdata_next = {{SPFS_ST_PAD_W{1'b0}}, mvalid_reg, pin_in_reg[6], mode_reg, fsel};
			end
			else
			begin
				pslverr_next = 1'b1; // Unmapped: error with zero data.
			end
		end
	end

	// Writes land only at the edge where the access phase completes; status words ignore writes.
	always_comb
	begin
		ctrl_next = ctrl_reg;
		dir_next  = dir_reg;
		data_next = data_reg;
		if (wr_acc)
		begin
			if (i_paddr == SPFS_OFS_CTRL)
			begin
				ctrl_next = i_pwdata[SPFS_CTRL_W-1:0];
			end
			else if (i_paddr == SPFS_OFS_DIR)
			begin
				dir_next = i_pwdata[SPFS_PIN_N-1:0];
			end
			else if (i_paddr == SPFS_OFS_DATA)
			begin
				data_next = i_pwdata[SPFS_PIN_N-1:0];
			end
		end
	end

	// All state, including pin drivers, clears under the external reset, releasing every pin.
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_b)
		begin
			ctrl_reg    <= SPFS_CTRL_RST;
			dir_reg     <= SPFS_DIR_RST;
			data_reg    <= SPFS_DATA_RST;
			prdata_reg  <= '0;
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			pout_reg    <= '0;
			poeb_reg    <= '1;
			pin_in_reg  <= '0;
			mode_reg    <= SPFS_MODE_RST;
			mvalid_reg  <= 1'b0;
			live_reg    <= 2'h0;
		end
		else
		begin
			ctrl_reg    <= ctrl_next;
			dir_reg     <= dir_next;
			data_reg    <= data_next;
			prdata_reg  <= prdata_next;
			pready_reg  <= pready_next;
			pslverr_reg <= pslverr_next;
			pout_reg    <= pout_next;
			poeb_reg    <= poeb_next;
			pin_in_reg  <= pin_in_next;
			mode_reg    <= mode_next;
			mvalid_reg  <= mvalid_next;
			live_reg    <= live_next;
		end
	end

	// Outputs come straight from flip-flops.
	assign o_prdata             = prdata_reg;
	assign o_pready             = pready_reg;
	assign o_pslverr            = pslverr_reg;
	assign o_pin_out            = pout_reg;
	assign o_pin_oe_b           = poeb_reg;
	assign o_serial_ch4_rx      = pin_in_reg[0];
	assign o_serial_ch4_clk_in  = pin_in_reg[1];
	assign o_sync_serial_rx     = pin_in_reg[2];
	assign o_sync_serial_clk_in = pin_in_reg[3];
	assign o_ser3_clk_in        = pin_in_reg[4];
	assign o_dma_ch2_request_in = pin_in_reg[5];
	assign o_nmi_req            = pin_in_reg[6];
	assign o_operating_mode     = mode_reg;
	assign o_mode_valid         = mvalid_reg;

	// Checks on pin selection, receive paths and the mode latch; pin checks tie a pin to the setting one edge earlier, path checks to the pin three edges earlier.
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_b);

	chk_h5_gpio_mode: assert property (
		!(ctrl_reg[SPFS_B_CH3_CLK_OUT] | ctrl_reg[SPFS_B_CH3_EXT_CLK])
		|=> o_pin_oe_b[SPFS_P_H_BIT5] == !$past(dir_reg[SPFS_P_H_BIT5]))
		else $error("port H bit 5 not under port control");
	chk_ch4_rx_path: assert property (
		live_reg == SPFS_LIVE_MAX |-> o_serial_ch4_rx == $past(i_pin[SPFS_P_G_BIT0], 3))
		else $error("channel 4 receive level not passed after three edges");
	chk_ch4_tx_drive: assert property (
		ctrl_reg[SPFS_B_CH4_TX_EN]
		|=> !o_pin_oe_b[SPFS_P_G_BIT1] && o_pin_out[SPFS_P_G_BIT1] == $past(i_serial_ch4_tx))
		else $error("channel 4 transmit not driven");
	chk_g1_gpio_mode: assert property (
		!ctrl_reg[SPFS_B_CH4_TX_EN]
		|=> o_pin_out[SPFS_P_G_BIT1] == $past(data_reg[SPFS_P_G_BIT1]))
		else $error("port G bit 1 data not on pin");
	chk_ch4_clk_serve: assert property (
		ctrl_reg[SPFS_B_CH4_EXT_CLK] && !ctrl_reg[SPFS_B_CH4_CLK_OUT]
		|=> o_pin_oe_b[SPFS_P_G_BIT2])
		else $error("channel 4 external clock pin is driven");
	chk_g2_gpio_mode: assert property (
		!ctrl_reg[SPFS_B_CH4_EXT_CLK] && !ctrl_reg[SPFS_B_CH4_CLK_OUT]
		|=> o_pin_oe_b[SPFS_P_G_BIT2] == !$past(dir_reg[SPFS_P_G_BIT2]) && !o_serial_ch4_clk_in)
		else $error("port G bit 2 not under port control");
	chk_sync_rx_off: assert property (
		!dir_reg[SPFS_P_G_BIT3] [*2] |-> o_pin_oe_b[SPFS_P_G_BIT3])
		else $error("sync receive pin driven with port direction input");
	chk_sync_tx_drive: assert property (
		ctrl_reg[SPFS_B_SYNC_TX_EN]
		|=> !o_pin_oe_b[SPFS_P_G_BIT4] && o_pin_out[SPFS_P_G_BIT4] == $past(i_sync_serial_tx))
		else $error("sync transmit not driven");
	chk_g4_gpio_mode: assert property (
		!ctrl_reg[SPFS_B_SYNC_TX_EN]
		|=> o_pin_oe_b[SPFS_P_G_BIT4] == !$past(dir_reg[SPFS_P_G_BIT4]))
		else $error("port G bit 4 not under port control");
	chk_sync_clk_out: assert property (
		ctrl_reg[SPFS_B_SYNC_CLK_OUT]
		|=> !o_pin_oe_b[SPFS_P_G_BIT5] && o_pin_out[SPFS_P_G_BIT5] == $past(i_sync_serial_clk_out))
		else $error("sync shift clock not driven");
	chk_g5_gpio_mode: assert property (
		!ctrl_reg[SPFS_B_SYNC_CLK_OUT] && !ctrl_reg[SPFS_B_SYNC_EXT_SHFT]
		|=> o_pin_out[SPFS_P_G_BIT5] == $past(data_reg[SPFS_P_G_BIT5]))
		else $error("port G bit 5 data not on pin");
	chk_mode_latch_hold: assert property (
		o_mode_valid |=> o_mode_valid && $stable(o_operating_mode))
		else $error("latched operating mode changed");
	chk_dma_req_path: assert property (
		ctrl_reg[SPFS_B_DMA2_REQ_SEL] && $past(ctrl_reg[SPFS_B_DMA2_REQ_SEL])
		&& live_reg == SPFS_LIVE_MAX
		|=> o_dma_ch2_request_in == $past(i_pin[SPFS_P_C_BIT0], 3))
		else $error("DMA request level not passed");
	chk_nmi_path: assert property (
		live_reg == SPFS_LIVE_MAX |-> o_nmi_req == $past(i_nmi_pin, 3))
		else $error("NMI level not passed after three edges");
	chk_port_c_off: assert property (
		!dir_reg[SPFS_P_C_BIT0] |=> o_pin_oe_b[SPFS_P_C_BIT0])
		else $error("port C bit 0 driven with direction input");

	cov_ch4_tx_on: cover property (!ctrl_reg[SPFS_B_CH4_TX_EN] ##1 ctrl_reg[SPFS_B_CH4_TX_EN]);
	cov_mode_caught: cover property (!o_mode_valid ##1 o_mode_valid);
	cov_dma_req_seen: cover property (o_dma_ch2_request_in);
	cov_apb_error: cover property (o_pready && o_pslverr);

endmodule : spfs_pin_mux

// *** logic/spfs_pkg.sv ***
package spfs_pkg;

	// Bus geometry.
	localparam int SPFS_ADDR_W = 12;
	localparam int SPFS_DATA_W = 32;

	// Register byte offsets.
	localparam logic [11:0] SPFS_OFS_CTRL   = 12'h000;
	localparam logic [11:0] SPFS_OFS_DIR    = 12'h004;
	localparam logic [11:0] SPFS_OFS_DATA   = 12'h008;
	localparam logic [11:0] SPFS_OFS_LEVEL  = 12'h00c;
	localparam logic [11:0] SPFS_OFS_STATUS = 12'h010;

	// Function control field positions.
	localparam int SPFS_CTRL_W          = 9;
	localparam int SPFS_B_CH3_CLK_OUT   = 0;
	localparam int SPFS_B_CH3_EXT_CLK   = 1;
	localparam int SPFS_B_CH4_TX_EN     = 2;
	localparam int SPFS_B_CH4_CLK_OUT   = 3;
	localparam int SPFS_B_CH4_EXT_CLK   = 4;
	localparam int SPFS_B_SYNC_TX_EN    = 5;
	localparam int SPFS_B_SYNC_CLK_OUT  = 6;
	localparam int SPFS_B_SYNC_EXT_SHFT = 7;
	localparam int SPFS_B_DMA2_REQ_SEL  = 8;

	// Shared pin indices.
	localparam int SPFS_PIN_N      = 8;
	localparam int SPFS_P_G_BIT0   = 0;
	localparam int SPFS_P_G_BIT1   = 1;
	localparam int SPFS_P_G_BIT2   = 2;
	localparam int SPFS_P_G_BIT3   = 3;
	localparam int SPFS_P_G_BIT4   = 4;
	localparam int SPFS_P_G_BIT5   = 5;
	localparam int SPFS_P_H_BIT5   = 6;
	localparam int SPFS_P_C_BIT0   = 7;

	// Other pin inputs that are synchronised with the shared pins.
	localparam int SPFS_MODE_W     = 3;
	localparam int SPFS_SYNC_W     = SPFS_PIN_N + 1 + SPFS_MODE_W;
	localparam int SPFS_S_NMI      = 8;
	localparam int SPFS_S_MODE_LSB = 9;

	// Reset values.
	localparam logic [8:0]  SPFS_CTRL_RST = 9'h000;
	localparam logic [7:0]  SPFS_DIR_RST  = 8'h00;
	localparam logic [7:0]  SPFS_DATA_RST = 8'h00;
	localparam logic [2:0]  SPFS_MODE_RST = 3'h0;

	// Edges after reset release at which the synchronised mode pins are valid.
	localparam logic [1:0]  SPFS_MODE_SETTLE = 2'h2;
	localparam logic [1:0]  SPFS_LIVE_MAX    = 2'h3;

	// Status word layout.
	localparam int SPFS_ST_PAD_W = SPFS_DATA_W - SPFS_PIN_N - SPFS_MODE_W - 2;

endpackage : spfs_pkg

// *** logic/spfs_sync2.sv ***
`timescale 1ns/10ps
module spfs_sync2
	import spfs_pkg::*;
#(
	parameter int WIDTH = 1
)
(
	// Clock and reset.
	input  wire logic             i_sys_clk,
	input  wire logic             i_rst_b,
	// Asynchronous levels in and their synchronised copies out.
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] meta_next;
	logic [WIDTH-1:0] sync_reg;
	logic [WIDTH-1:0] sync_next;

	// The first stage feeds only the second stage, so metastability has a full cycle to settle.
	always_comb
	begin
		meta_next = i_async;
		sync_next = meta_reg;
	end

	// Both stages clear on reset so that nothing downstream sees an unknown level.
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_b)
		begin
			meta_reg <= '0;
			sync_reg <= '0;
		end
		else
		begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
		end
	end

	assign o_sync = sync_reg;

endmodule : spfs_sync2

// *** tb/spfs_board_model.sv ***
`timescale 1ns/10ps
module spfs_board_model
	import spfs_pkg::*;
#(
	parameter logic [SPFS_MODE_W-1:0] MODE_STRAP = 3'h5
)
(
	// Pin drive coming from the device.
	input  wire logic [SPFS_PIN_N-1:0]  i_pin_out,
	input  wire logic [SPFS_PIN_N-1:0]  i_pin_oe_b,
	// Levels that the external parts put on the lines they own.
	input  wire logic [SPFS_PIN_N-1:0]  i_ext_val,
	// Resolved pin levels and strap levels.
	output logic      [SPFS_PIN_N-1:0]  o_pin,
	output logic      [SPFS_MODE_W-1:0] o_mode_pins
);
	// Straps are tied to fixed rails, so they never move during a run.
	assign o_mode_pins = MODE_STRAP;

	// Receivers, clock sources and request lines drive a pin only once the device lets go.
	always_comb
	begin
		o_pin = (i_pin_oe_b & i_ext_val) | (~i_pin_oe_b & i_pin_out);
	end
endmodule : spfs_board_model

// *** tb/spfs_pin_mux_tb.sv ***
`timescale 1ns/10ps
module spfs_pin_mux_tb
	import spfs_pkg::*;
;
	typedef struct packed {
		logic [31:0] data;
		logic [31:0] mask;
		logic        err;
	} spfs_tb_exp_s;

	logic                   sys_clk = 1'b0;
	logic                   rst_b;
	logic                   psel;
	logic                   penable;
	logic                   pwrite;
	logic [SPFS_ADDR_W-1:0] paddr;
	logic [SPFS_DATA_W-1:0] pwdata;
	logic [SPFS_DATA_W-1:0] prdata;
	logic                   pready;
	logic                   pslverr;
	logic [SPFS_PIN_N-1:0]  pin;
	logic [SPFS_PIN_N-1:0]  pin_out;
	logic [SPFS_PIN_N-1:0]  pin_oe_b;
	logic [SPFS_PIN_N-1:0]  ext_val;
	logic                   nmi;
	logic [SPFS_MODE_W-1:0] mode_pins;
	logic [SPFS_MODE_W-1:0] op_mode;
	logic [4:0]             per_in;
	logic [7:0]             per_out;
	int                     n_errors = 0;
	int                     tests_run = 0;
	integer                 seed = 69;
	spfs_tb_exp_s           expq[$];
	spfs_tb_exp_s           exp_e;
	logic [8:0]             ctab [13] = '{9'h000, 9'h001, 9'h002, 9'h003, 9'h004, 9'h008,
		9'h010, 9'h018, 9'h020, 9'h040, 9'h080, 9'h0c0, 9'h100};

	// The bench clock runs at 250 MHz.
	always #2 sys_clk = ~sys_clk;

	spfs_pin_mux i_spfs_pin_mux (
		.i_sys_clk(sys_clk), .i_rst_b(rst_b), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_pin(pin), .o_pin_out(pin_out),
		.o_pin_oe_b(pin_oe_b), .i_nmi_pin(nmi), .i_operating_mode_pins(mode_pins),
		.i_ser3_clk_out(per_in[4]), .o_ser3_clk_in(per_out[7]),
		.i_serial_ch4_tx(per_in[3]), .i_serial_ch4_clk_out(per_in[2]),
		.o_serial_ch4_rx(per_out[6]), .o_serial_ch4_clk_in(per_out[5]),
		.i_sync_serial_tx(per_in[1]), .i_sync_serial_clk_out(per_in[0]),
		.o_sync_serial_rx(per_out[4]), .o_sync_serial_clk_in(per_out[3]),
		.o_dma_ch2_request_in(per_out[2]), .o_nmi_req(per_out[1]),
		.o_operating_mode(op_mode), .o_mode_valid(per_out[0]));

	spfs_board_model i_spfs_board_model (
		.i_pin_out(pin_out), .i_pin_oe_b(pin_oe_b), .i_ext_val(ext_val), .o_pin(pin),
		.o_mode_pins(mode_pins));

	task automatic cmp_bus(input logic [31:0] got, input logic [31:0] exp, input string msg);
		tests_run++;
		if (got !== exp)
		begin
			n_errors++;
			$display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask : cmp_bus

	task automatic cmp_pin(input logic [7:0] got, input logic [7:0] exp, input string msg);
		tests_run++;
		if (got !== exp)
		begin
			n_errors++;
			$display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask : cmp_pin

	task finish_test();
		$display("comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : finish_test

	// One APB transfer; the expected answer is queued for the monitor before the setup.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [31:0] ex, input logic [31:0] m, input logic er);
		expq.push_back(spfs_tb_exp_s'{ex & m, m, er});
		@(posedge sys_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1)
			@(posedge sys_clk);
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// The monitor takes the oldest note whenever the slave answers.
	always @(posedge sys_clk)
	begin
		if (psel && penable && pready === 1'b1 && expq.size() > 0)
		begin
			exp_e = expq.pop_front();
			cmp_bus(prdata & exp_e.mask, exp_e.data, "read data");
			cmp_bus({31'h0, pslverr}, {31'h0, exp_e.err}, "slave error");
		end
	end

	// Reference pin selection; a driving clock output wins over an external clock.
	function automatic logic [15:0] ref_pins(input logic [8:0] c, input logic [7:0] dr,
		input logic [7:0] dt, input logic [4:0] p);
		logic [7:0] oe;
		logic [7:0] o;
		oe = ~dr;
		o = dt;
		oe[1] = c[SPFS_B_CH4_TX_EN] ? 1'b0 : ~dr[1];
		o[1] = c[SPFS_B_CH4_TX_EN] ? p[3] : dt[1];
		oe[2] = c[SPFS_B_CH4_CLK_OUT] ? 1'b0 : (c[SPFS_B_CH4_EXT_CLK] | ~dr[2]);
		o[2] = c[SPFS_B_CH4_CLK_OUT] ? p[2] : dt[2];
		oe[4] = c[SPFS_B_SYNC_TX_EN] ? 1'b0 : ~dr[4];
		o[4] = c[SPFS_B_SYNC_TX_EN] ? p[1] : dt[4];
		oe[5] = c[SPFS_B_SYNC_CLK_OUT] ? 1'b0 : (c[SPFS_B_SYNC_EXT_SHFT] | ~dr[5]);
		o[5] = c[SPFS_B_SYNC_CLK_OUT] ? p[0] : dt[5];
		oe[6] = c[SPFS_B_CH3_CLK_OUT] ? 1'b0 : (c[SPFS_B_CH3_EXT_CLK] | ~dr[6]);
		o[6] = c[SPFS_B_CH3_CLK_OUT] ? p[4] : dt[6];
		return {oe, o};
	endfunction : ref_pins

	// Program one setting, let the pins and synchronisers settle, then check both sides.
	task automatic run_case(input logic [31:0] c, input logic [31:0] dr, input logic [31:0] dt,
		input logic [4:0] p, input logic [7:0] ev, input logic nm);
		logic [15:0] r;
		logic [7:0]  lvl;
		per_in  <= p;
		ext_val <= ev;
		nmi     <= nm;
		apb(1'b1, SPFS_OFS_CTRL, c, 32'h0, 32'h0, 1'b0);
		apb(1'b1, SPFS_OFS_DIR, dr, 32'h0, 32'h0, 1'b0);
		apb(1'b1, SPFS_OFS_DATA, dt, 32'h0, 32'h0, 1'b0);
		repeat (5) @(posedge sys_clk);
		r = ref_pins(c[8:0], dr[7:0], dt[7:0], p);
		lvl = (r[15:8] & ev) | (~r[15:8] & r[7:0]);
		cmp_pin(pin_oe_b, r[15:8], "pin enable");
		cmp_pin(pin_out, r[7:0], "pin drive");
		cmp_pin(per_out, {lvl[6] & c[1], lvl[0], lvl[2] & c[4], lvl[3], lvl[5] & c[7],
			lvl[7] & c[8], nm, 1'b1}, "peripheral in");
		cmp_pin({5'h0, op_mode}, 8'h05, "mode");
		apb(1'b0, SPFS_OFS_CTRL, 32'h0, c, 32'h1ff, 1'b0);
		apb(1'b0, SPFS_OFS_DIR, 32'h0, dr, 32'hff, 1'b0);
		apb(1'b0, SPFS_OFS_DATA, 32'h0, dt, 32'hff, 1'b0);
		apb(1'b0, SPFS_OFS_LEVEL, 32'h0, {24'h0, lvl}, 32'hffffffff, 1'b0);
		apb(1'b0, SPFS_OFS_STATUS, 32'h0, {19'h0, 1'b1, nm, 3'h5, 1'b0, c[0] | c[1], c[6] | c[7],
			c[5], 1'b0, c[3] | c[4], c[2], 1'b0}, 32'h1fff, 1'b0);
	endtask : run_case

	// Main sequence: reset state, bus refusals, every control bit, then random settings.
	initial
	begin
		rst_b = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		ext_val = 8'h00;
		nmi = 1'b0;
		per_in = 5'h00;
		repeat (16) @(posedge sys_clk);
		rst_b <= 1'b1;
		@(posedge sys_clk);
		cmp_pin(pin_oe_b, 8'hff, "reset enable");
		cmp_pin(pin_out, 8'h00, "reset drive");
		apb(1'b0, SPFS_OFS_DIR, 32'h0, 32'h0, 32'hffffffff, 1'b0);
		$display("test reset done");
		apb(1'b0, 12'h014, 32'h0, 32'h0, 32'hffffffff, 1'b1);
		apb(1'b1, 12'h020, 32'h1ff, 32'h0, 32'h0, 1'b1);
		apb(1'b1, SPFS_OFS_LEVEL, 32'hff, 32'h0, 32'h0, 1'b0);
		apb(1'b0, SPFS_OFS_CTRL, 32'h0, 32'h0, 32'hffffffff, 1'b0);
		$display("test bus done");
		run_case(32'h0, 32'hff, $random(seed), 5'h1f, 8'h00, 1'b1);
		foreach (ctab[k])
			run_case({23'h0, ctab[k]}, $random(seed) & 32'hff76, $random(seed),
				$random(seed), $random(seed), $random(seed));
		$display("test control table done");
		repeat (12)
			run_case($random(seed), $random(seed) & 32'hff76, $random(seed),
				$random(seed), $random(seed), $random(seed));
		$display("test random done");
		rst_b <= 1'b0;
		repeat (3) @(posedge sys_clk);
		cmp_pin(pin_oe_b, 8'hff, "second reset");
		rst_b <= 1'b1;
		apb(1'b0, SPFS_OFS_CTRL, 32'h0, 32'h0, 32'hffffffff, 1'b0);
		$display("test second reset done");
		finish_test();
	end

	// A hang is cut short well after the sequence should have ended.
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		n_errors++;
		finish_test();
	end
endmodule : spfs_pin_mux_tb
